// ### bench/ddc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Host controller on the serial register port
// ************************************************************
module ddc_host_model (
  input wire logic ref_clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdio_line
);
  logic sdo = 1'b0;
  logic sdo_oe = 1'b0;
  logic park = 1'b0;
  logic lsb = 1'b0;
  logic lng = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // Undriven line wanders, so a stale bit never reads as valid
  always @(posedge ref_clk) park <= ~park;
  assign sdio_line = sdio_oe ? sdio_out : (sdo_oe ? sdo : park);
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data changes while sclk is low; read bit taken at the rise
  task automatic xbyte(input logic [7:0] w, input logic drv, output logic [7:0] r);
    int k;
    for (int i = 0; i < 8; i++) begin
      k = lsb ? i : 7 - i;
      sclk = 1'b0;
      sdo = w[k];
      sdo_oe = drv;
      idle(5);
      sclk = 1'b1;
      r[k] = sdio_line;
      idle(5);
    end
  endtask
  // Callers switch order or address length only in one-byte frames
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] w0,
                       input logic [7:0] w1, input int n, output logic [7:0] r0,
                       output logic [7:0] r1);
    logic [15:0] iw;
    logic [7:0] junk;
    iw = lng ? {rd, 2'b00, a} : {8'h00, rd, 2'b00, a[4:0]};
    r1 = 8'h00;
    cs_n = 1'b0;
    idle(5);
    if (lng) begin
      xbyte(lsb ? iw[7:0] : iw[15:8], 1'b1, junk);
      xbyte(lsb ? iw[15:8] : iw[7:0], 1'b1, junk);
    end else begin
      xbyte(iw[7:0], 1'b1, junk);
    end
    xbyte(w0, !rd, r0);
    if (n > 1) xbyte(w1, !rd, r1);
    sclk = 1'b0;
    sdo_oe = 1'b0;
    idle(5);
    cs_n = 1'b1;
    idle(8);
  endtask
endmodule
`default_nettype wire

// ### bench/dual_dac_control_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ************************************************************
// Register bank bench
// ************************************************************
module dual_dac_control_registers_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wire logic cs_n;
  wire logic sclk;
  wire logic sdio_line;
  wire logic sdio_out;
  wire logic sdio_oe;
  wire ddc_pkg::ddc_ctrl_type ctrl;
  int n_tests = 0;
  int n_mismatch = 0;
  logic [7:0] q;
  logic [7:0] q1;
  ddc_ctrl_regs ddc_ctrl_regs_inst (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .ctrl(ctrl));
  ddc_host_model ddc_host_model_inst (.ref_clk(ref_clk), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .cs_n(cs_n), .sclk(sclk), .sdio_line(sdio_line));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    ddc_host_model_inst.frame(1'b0, a, d, 8'h00, 1, q, q1);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    ddc_host_model_inst.frame(1'b1, a, 8'h00, 8'h00, 1, q, q1);
    `CHK(q, e)
    `CHK(sdio_oe, 1'b0)
  endtask
  task automatic t_defaults;
    `CHK(ctrl, 24'h080D00)
    rd_chk(13'h0, 8'h00);
    rd_chk(13'h1, 8'h40);
    rd_chk(13'h2, 8'h34);
    rd_chk(13'h3, 8'h00);
  endtask
  task automatic t_power;
    wr(13'h1, 8'hFF);
    rd_chk(13'h1, 8'hBF);
    `CHK(ctrl, 24'h17ED00)
    wr(13'h1, 8'h15);
    rd_chk(13'h1, 8'h55);
    `CHK(ctrl, 24'h0AAD00)
    wr(13'h1, 8'h0A);
    `CHK(ctrl, 24'h094D00)
  endtask
  task automatic t_data;
    wr(13'h2, 8'hFF);
    rd_chk(13'h2, 8'hBF);
    `CHK(ctrl[12:6], 7'h7B)
    wr(13'h2, 8'h86);
    `CHK(ctrl[12:6], 7'h46)
    wr(13'h2, 8'h0D);
    `CHK(ctrl[12:6], 7'h09)
  endtask
  task automatic t_gain;
    wr(13'h3, 8'hFF);
    rd_chk(13'h3, 8'h3F);
    `CHK(ctrl.i_fine_gain, 6'h3F)
    wr(13'h5, 8'hFF);
    rd_chk(13'h5, 8'h00);
    ddc_host_model_inst.frame(1'b0, 13'h3, 8'h15, 8'h2A, 2, q, q1);
    rd_chk(13'h2, 8'h2A);
    rd_chk(13'h3, 8'h15);
  endtask
  task automatic t_order;
    wr(13'h0, 8'h40);
    ddc_host_model_inst.lsb = 1'b1;
    `CHK(ctrl.bit_order_sel, 1'b1)
    ddc_host_model_inst.frame(1'b1, 13'h2, 8'h00, 8'h00, 2, q, q1);
    `CHK({q, q1}, 16'h2A15)
    wr(13'h0, 8'h50);
    ddc_host_model_inst.lng = 1'b1;
    `CHK(ctrl.long_address_sel, 1'b1)
    rd_chk(13'h1003, 8'h00);
    rd_chk(13'h0003, 8'h15);
    // Back to MSB first with long instructions kept, in a one-byte frame
    wr(13'h0, 8'h10);
    ddc_host_model_inst.lsb = 1'b0;
    rd_chk(13'h1002, 8'h00);
    ddc_host_model_inst.frame(1'b1, 13'h3, 8'h00, 8'h00, 2, q, q1);
    `CHK({q, q1}, 16'h152A)
    wr(13'h0, 8'h00);
    ddc_host_model_inst.lng = 1'b0;
    rd_chk(13'h0, 8'h00);
  endtask
  task automatic t_soft;
    wr(13'h0, 8'h20);
    `CHK(ctrl.soft_reset_active, 1'b1)
    rd_chk(13'h3, 8'h00);
    rd_chk(13'h2, 8'h34);
    wr(13'h3, 8'h11);
    rd_chk(13'h3, 8'h00);
    rd_chk(13'h0, 8'h20);
    // Release in a later frame
    wr(13'h0, 8'h00);
    `CHK(ctrl.soft_reset_active, 1'b0)
    wr(13'h3, 8'h11);
    rd_chk(13'h3, 8'h11);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, about eight times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_defaults();
    t_power();
    t_data();
    t_gain();
    t_order();
    t_soft();
    wrap_up();
  end
endmodule
`default_nettype wire

// ### common/ddc_consts.svh
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define DDC_ADDR_SPC 13'h0000
`define DDC_ADDR_PWR 13'h0001
`define DDC_ADDR_DIC 13'h0002
`define DDC_ADDR_GAIN 13'h0003

// ************************************************************
// Field positions
// ************************************************************
`define DDC_SPC_BIT_ORDER 6
`define DDC_SPC_SOFT_RESET 5
`define DDC_SPC_LONG_ADDR 4
`define DDC_PWR_REG_OFF 7
`define DDC_PWR_REG_ON_FLAG 6
`define DDC_PWR_SLEEP 5
`define DDC_PWR_Q_OUT_DIS 4
`define DDC_PWR_I_OUT_DIS 3
`define DDC_PWR_Q_CLK_GATE 2
`define DDC_PWR_I_CLK_GATE 1
`define DDC_PWR_REF_OFF 0
`define DDC_DIC_TWOS 7
`define DDC_DIC_PAIR_ORDER 5
`define DDC_DIC_RISE_CHAN 4
`define DDC_DIC_EXCL 3
`define DDC_DIC_CLK_IN 2
`define DDC_DIC_CLK_OUT 1
`define DDC_DIC_CLK_BOOST 0
`define DDC_GAIN_MSB 5
`define DDC_GAIN_LSB 0
`define DDC_INST_RW_SHORT 7
`define DDC_INST_RW_LONG 15
`define DDC_INST_ADDR_SHORT_MSB 4
`define DDC_INST_ADDR_LONG_MSB 12

// ************************************************************
// Reset values and writable-bit masks
// ************************************************************
`define DDC_SPC_RESET 8'h00
`define DDC_PWR_RESET 8'h40
`define DDC_DIC_RESET 8'h34
`define DDC_GAIN_RESET 8'h00
`define DDC_SPC_MASK 8'h70
`define DDC_PWR_MASK 8'hBF
`define DDC_DIC_MASK 8'hBF
`define DDC_GAIN_MASK 8'h3F

// ************************************************************
// Serial timing
// ************************************************************
`define DDC_BYTE_LAST_BIT 3'h7
`define DDC_PIN_IDLE 3'h4

`endif

// ### common/ddc_pkg.sv
`default_nettype none
package ddc_pkg;

  // Serial engine phases
  typedef enum logic [1:0] {
    ST_INST,
    ST_WDATA,
    ST_RDATA,
    ST_HOLD
  } ddc_state_type;

  // Serial pins as seen by the core
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } ddc_pins_type;

  // Edge events derived from the synchronised pins
  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic frame_idle;
  } ddc_edges_type;

  // Control word driven to the converter core
  typedef struct packed {
    logic bit_order_sel;
    logic long_address_sel;
    logic soft_reset_active;
    logic core_regulator_off;
    logic core_regulator_on_flag;
    logic global_sleep;
    logic q_output_disable;
    logic i_output_disable;
    logic q_clock_gate;
    logic i_clock_gate;
    logic internal_ref_off;
    logic input_twos_sel;
    logic pair_order_sel;
    logic rising_edge_channel_sel;
    logic bidir_exclusive_sel;
    logic data_clock_in_en;
    logic data_clock_out_en;
    logic data_clock_out_boost;
    logic [5:0] i_fine_gain;
  } ddc_ctrl_type;

endpackage
`default_nettype wire

// ### verilog/ddc_ctrl_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddc_consts.svh"

// How it works
// - Defined bits other than power bit 6 read back last written value
// - Port control bit 6 picks bit order
// - Soft reset restores all other registers
// - Soft reset holds until host writes zero
// - Port control bit 4 picks address length
// - Power bit 7 turns core regulator off
// - Power bit 6 reports regulator on
// - Power bit 5 sleeps all but serial port
// - Bits 4 and 3 disable Q/I outputs
// - Bits 2 and 1 stop Q/I clocks
// - Power bit 0 turns internal reference off
// - Data bit 7 selects twos complement input
// - Data bit 5 selects I-first pairing
// - Data bit 4 selects rising-edge channel
// - Data bit 3 forbids clock pin both ways
// - Data bit 2 enables clock pin input
// - Data bit 1 enables clock pin output
// - Data bit 0 adds second output driver
// - Gain bits 5:0 hold I fine gain
// - Port configuration applies on its last bit
module ddc_ctrl_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output wire logic sdio_out,
  output wire logic sdio_oe,
  output wire ddc_pkg::ddc_ctrl_type ctrl
);

  // ************************************************************
  // Control word mapping
  // ************************************************************
  function automatic ddc_pkg::ddc_ctrl_type map_ctrl(
    input logic [7:0] spc,
    input logic [7:0] pwr,
    input logic [7:0] dic,
    input logic [7:0] gain
  );
    ddc_pkg::ddc_ctrl_type c;
    logic excl;
    excl = dic[`DDC_DIC_EXCL];
    c.bit_order_sel = spc[`DDC_SPC_BIT_ORDER];
    c.long_address_sel = spc[`DDC_SPC_LONG_ADDR];
    c.soft_reset_active = spc[`DDC_SPC_SOFT_RESET];
    c.core_regulator_off = pwr[`DDC_PWR_REG_OFF];
    c.core_regulator_on_flag = ~pwr[`DDC_PWR_REG_OFF];
    c.global_sleep = pwr[`DDC_PWR_SLEEP];
    c.q_output_disable = pwr[`DDC_PWR_Q_OUT_DIS];
    c.i_output_disable = pwr[`DDC_PWR_I_OUT_DIS];
    c.q_clock_gate = pwr[`DDC_PWR_Q_CLK_GATE];
    c.i_clock_gate = pwr[`DDC_PWR_I_CLK_GATE];
    c.internal_ref_off = pwr[`DDC_PWR_REF_OFF];
    c.input_twos_sel = dic[`DDC_DIC_TWOS];
    c.pair_order_sel = dic[`DDC_DIC_PAIR_ORDER];
    c.rising_edge_channel_sel = dic[`DDC_DIC_RISE_CHAN];
    c.bidir_exclusive_sel = excl;
    // Output wins when both directions are asked for under exclusion
    c.data_clock_in_en = dic[`DDC_DIC_CLK_IN]
      & ~(excl & (dic[`DDC_DIC_CLK_OUT] | dic[`DDC_DIC_CLK_BOOST]));
    c.data_clock_out_en = dic[`DDC_DIC_CLK_OUT];
    c.data_clock_out_boost = dic[`DDC_DIC_CLK_BOOST];
    c.i_fine_gain = gain[`DDC_GAIN_MSB:`DDC_GAIN_LSB];
    return c;
  endfunction

  localparam logic [7:0] PWR_STORED_RST = `DDC_PWR_RESET & `DDC_PWR_MASK;
  localparam logic [7:0] DIC_STORED_RST = `DDC_DIC_RESET & `DDC_DIC_MASK;
  localparam logic [7:0] GAIN_STORED_RST = `DDC_GAIN_RESET & `DDC_GAIN_MASK;
  localparam ddc_pkg::ddc_ctrl_type CTRL_RST =
    map_ctrl(`DDC_SPC_RESET, PWR_STORED_RST, DIC_STORED_RST, GAIN_STORED_RST);

  // ************************************************************
  // Declarations
  // ************************************************************
  ddc_pkg::ddc_pins_type raw_pins;
  ddc_pkg::ddc_pins_type pins;
  ddc_pkg::ddc_edges_type edges;
  ddc_pkg::ddc_state_type st_reg, st_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] inst_first_reg, inst_first_next;
  logic inst_byte_reg, inst_byte_next;
  logic [12:0] addr_reg, addr_next;
  logic [7:0] tx_reg, tx_next;
  logic sdio_out_reg, sdio_out_next;
  logic sdio_oe_reg, sdio_oe_next;
  logic [7:0] serial_port_control_reg, serial_port_control_next;
  logic [7:0] power_control_reg, power_control_next;
  logic [7:0] data_interface_control_reg, data_interface_control_next;
  logic [7:0] i_channel_gain_reg, i_channel_gain_next;
  ddc_pkg::ddc_ctrl_type ctrl_reg, ctrl_next;

  logic msb_first;
  logic long_mode;
  logic soft_rst_active;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [15:0] inst_word;
  logic inst_done;
  logic inst_rw;
  logic [12:0] inst_addr;
  logic [12:0] addr_inc;
  logic [12:0] addr_dec;
  logic [12:0] addr_full;
  logic [12:0] addr_step;
  logic [12:0] load_addr;
  logic wr_fire;
  logic wr_spc;
  logic wr_pwr;
  logic wr_dic;
  logic wr_gain;
  logic regulator_on;
  logic [7:0] rd_pwr;
  logic [7:0] rd_byte;

  // ************************************************************
  // Pin front end
  // ************************************************************
  assign raw_pins = '{cs_n: cs_n, sclk: sclk, sdi: sdio_in};

  ddc_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(raw_pins),
    .synced(pins)
  );

  ddc_edge u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins(pins),
    .edges(edges)
  );

  // ************************************************************
  // Byte assembly and instruction decode
  // ************************************************************
  // Mode bits are read live, so a new setting steers the very next bit
  assign msb_first = ~serial_port_control_reg[`DDC_SPC_BIT_ORDER];
  assign long_mode = serial_port_control_reg[`DDC_SPC_LONG_ADDR];
  assign soft_rst_active = serial_port_control_reg[`DDC_SPC_SOFT_RESET];
  // A bit-order change mid-byte would scramble the rest of it
  assign rx_byte = msb_first ? {shift_reg[6:0], pins.sdi}
                             : {pins.sdi, shift_reg[7:1]};
  assign byte_done = edges.sclk_rise & (bit_cnt_reg == `DDC_BYTE_LAST_BIT);
  // The first byte of a long instruction is the high half only in MSB order
  assign inst_word = msb_first ? {inst_first_reg, rx_byte} : {rx_byte, inst_first_reg};
  assign inst_done = (st_reg == ddc_pkg::ST_INST) & byte_done
                   & (~long_mode | inst_byte_reg);
  assign inst_rw = long_mode ? inst_word[`DDC_INST_RW_LONG] : rx_byte[`DDC_INST_RW_SHORT];
  assign inst_addr = long_mode ? inst_word[`DDC_INST_ADDR_LONG_MSB:0]
                               : {8'h00, rx_byte[`DDC_INST_ADDR_SHORT_MSB:0]};

  // Address walks down in MSB order, up in LSB order, wrapping in its field
  assign addr_inc = addr_reg + 13'h0001;
  assign addr_dec = addr_reg - 13'h0001;
  assign addr_full = msb_first ? addr_dec : addr_inc;
  assign addr_step = long_mode ? addr_full
                               : {8'h00, addr_full[`DDC_INST_ADDR_SHORT_MSB:0]};
  assign load_addr = (st_reg == ddc_pkg::ST_INST) ? inst_addr : addr_step;

  // ************************************************************
  // Register write strobes and read mux
  // ************************************************************
  assign wr_fire = byte_done & (st_reg == ddc_pkg::ST_WDATA);
  assign wr_spc = wr_fire & (addr_reg == `DDC_ADDR_SPC);
  assign wr_pwr = wr_fire & (addr_reg == `DDC_ADDR_PWR);
  assign wr_dic = wr_fire & (addr_reg == `DDC_ADDR_DIC);
  assign wr_gain = wr_fire & (addr_reg == `DDC_ADDR_GAIN);

  // Status bit is not stored; it follows the regulator control
  assign regulator_on = ~power_control_reg[`DDC_PWR_REG_OFF];
  assign rd_pwr = power_control_reg | ({7'h00, regulator_on} << `DDC_PWR_REG_ON_FLAG);
  // Unmapped addresses read zero
  assign rd_byte = (load_addr == `DDC_ADDR_SPC) ? serial_port_control_reg :
                   (load_addr == `DDC_ADDR_PWR) ? rd_pwr :
                   (load_addr == `DDC_ADDR_DIC) ? data_interface_control_reg :
                   (load_addr == `DDC_ADDR_GAIN) ? i_channel_gain_reg : 8'h00;

  // Masks drop reserved bits; soft reset pins the others at defaults
  assign serial_port_control_next = wr_spc ? (rx_byte & `DDC_SPC_MASK)
                                           : serial_port_control_reg;
  assign power_control_next = soft_rst_active ? PWR_STORED_RST :
                              wr_pwr ? (rx_byte & `DDC_PWR_MASK) : power_control_reg;
  assign data_interface_control_next = soft_rst_active ? DIC_STORED_RST :
                              wr_dic ? (rx_byte & `DDC_DIC_MASK) : data_interface_control_reg;
  assign i_channel_gain_next = soft_rst_active ? GAIN_STORED_RST :
                              wr_gain ? (rx_byte & `DDC_GAIN_MASK) : i_channel_gain_reg;
  assign ctrl_next = map_ctrl(serial_port_control_reg, power_control_reg,
                              data_interface_control_reg, i_channel_gain_reg);

  // ************************************************************
  // Serial engine
  // ************************************************************
  // Read bits change on the falling edge so the host samples them stable
  always_comb begin
    st_next = st_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    inst_first_next = inst_first_reg;
    inst_byte_next = inst_byte_reg;
    addr_next = addr_reg;
    tx_next = tx_reg;
    sdio_out_next = sdio_out_reg;
    sdio_oe_next = sdio_oe_reg;
    if (edges.frame_idle) begin
      st_next = ddc_pkg::ST_INST;
      bit_cnt_next = 3'h0;
      inst_byte_next = 1'h0;
      sdio_oe_next = 1'h0;
    end else begin
      if (edges.sclk_rise) begin
        shift_next = rx_byte;
        bit_cnt_next = bit_cnt_reg + 3'h1;
      end
      unique case (st_reg)
        ddc_pkg::ST_INST: begin
          if (inst_done) begin
            addr_next = inst_addr;
            tx_next = rd_byte;
            st_next = inst_rw ? ddc_pkg::ST_RDATA : ddc_pkg::ST_WDATA;
          end else if (byte_done) begin
            inst_byte_next = 1'h1;
            inst_first_next = rx_byte;
          end
        end
        ddc_pkg::ST_WDATA: begin
          if (byte_done) begin
            addr_next = addr_step;
            // Serial port is held quiet for the rest of this frame
            if (wr_spc && rx_byte[`DDC_SPC_SOFT_RESET]) begin
              st_next = ddc_pkg::ST_HOLD;
            end
          end
        end
        ddc_pkg::ST_RDATA: begin
          if (byte_done) begin
            addr_next = addr_step;
            tx_next = rd_byte;
          end else if (edges.sclk_fall) begin
            sdio_out_next = msb_first ? tx_reg[7] : tx_reg[0];
            tx_next = msb_first ? {tx_reg[6:0], 1'h0} : {1'h0, tx_reg[7:1]};
            sdio_oe_next = 1'h1;
          end
        end
        ddc_pkg::ST_HOLD: begin
        end
      endcase
    end
  end

  // Engine state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= ddc_pkg::ST_INST;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      inst_first_reg <= 8'h00;
      inst_byte_reg <= 1'h0;
      addr_reg <= 13'h0000;
      tx_reg <= 8'h00;
      sdio_out_reg <= 1'h0;
      sdio_oe_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      inst_first_reg <= inst_first_next;
      inst_byte_reg <= inst_byte_next;
      addr_reg <= addr_next;
      tx_reg <= tx_next;
      sdio_out_reg <= sdio_out_next;
      sdio_oe_reg <= sdio_oe_next;
    end
  end

  // Register bank and registered control word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_port_control_reg <= `DDC_SPC_RESET;
      power_control_reg <= PWR_STORED_RST;
      data_interface_control_reg <= DIC_STORED_RST;
      i_channel_gain_reg <= GAIN_STORED_RST;
      ctrl_reg <= CTRL_RST;
    end else begin
      serial_port_control_reg <= serial_port_control_next;
      power_control_reg <= power_control_next;
      data_interface_control_reg <= data_interface_control_next;
      i_channel_gain_reg <= i_channel_gain_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign sdio_out = sdio_out_reg;
  assign sdio_oe = sdio_oe_reg;
  assign ctrl = ctrl_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
    wr_gain && !soft_rst_active |=> i_channel_gain_reg == ($past(rx_byte) & `DDC_GAIN_MASK))
    else $error("gain register did not take the written byte");
  AST_BIT_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    edges.sclk_rise |=> ($past(msb_first) ? shift_reg[0] : shift_reg[7]) == $past(pins.sdi))
    else $error("serial bit entered at the wrong end");
  AST_SOFT_DEFAULTS: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst_active |=> power_control_reg == PWR_STORED_RST
      && data_interface_control_reg == DIC_STORED_RST && i_channel_gain_reg == GAIN_STORED_RST)
    else $error("soft reset did not restore defaults");
  AST_SOFT_STAYS: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst_active && !wr_spc |=> soft_rst_active)
    else $error("soft reset released without a write");
  AST_SHORT_INST: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg == ddc_pkg::ST_INST && byte_done && !long_mode |=> st_reg != ddc_pkg::ST_INST)
    else $error("short instruction took more than one byte");
  AST_LONG_INST: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg == ddc_pkg::ST_INST && byte_done && long_mode && !inst_byte_reg
      |=> st_reg == ddc_pkg::ST_INST && inst_byte_reg)
    else $error("long instruction ended after one byte");
  AST_REG_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    power_control_reg[`DDC_PWR_REG_OFF] |=> ctrl_reg.core_regulator_off)
    else $error("regulator off not driven");
  AST_REG_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 ctrl_reg.core_regulator_on_flag == !$past(power_control_reg[`DDC_PWR_REG_OFF]))
    else $error("regulator status disagrees with control");
  AST_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(power_control_reg[`DDC_PWR_SLEEP]) |=> ctrl_reg.global_sleep)
    else $error("sleep not driven");
  AST_DCLK_EXCL: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_reg.bidir_exclusive_sel
      |-> !(ctrl_reg.data_clock_in_en && (ctrl_reg.data_clock_out_en
        || ctrl_reg.data_clock_out_boost)))
    else $error("clock pin enabled both ways under exclusion");
  AST_GAIN_OUT: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 ctrl_reg.i_fine_gain == $past(i_channel_gain_reg[`DDC_GAIN_MSB:`DDC_GAIN_LSB]))
    else $error("fine gain output lags wrongly");
  AST_CFG_IMMEDIATE: assert property (@(posedge ref_clk) disable iff (rst)
    wr_spc |=> serial_port_control_reg == ($past(rx_byte) & `DDC_SPC_MASK))
    else $error("port configuration not applied at once");
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    (serial_port_control_reg & ~`DDC_SPC_MASK) == 8'h00
      && (i_channel_gain_reg & ~`DDC_GAIN_MASK) == 8'h00
      && (data_interface_control_reg & ~`DDC_DIC_MASK) == 8'h00)
    else $error("reserved bit held a one");

endmodule
`default_nettype wire

// ### verilog/ddc_edge.sv
`timescale 1ns/100ps
`default_nettype none

module ddc_edge (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ddc_pkg::ddc_pins_type pins,
  output wire ddc_pkg::ddc_edges_type edges
);

  logic sclk_prev_reg;

  // ************************************************************
  // Clock edge detection inside a frame
  // ************************************************************
  // Edges outside a frame are dropped so stray clocks do nothing
  assign edges.sclk_rise = pins.sclk & ~sclk_prev_reg & ~pins.cs_n;
  assign edges.sclk_fall = ~pins.sclk & sclk_prev_reg & ~pins.cs_n;
  assign edges.frame_idle = pins.cs_n;

  // Previous clock level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'h0;
    end else begin
      sclk_prev_reg <= pins.sclk;
    end
  end

endmodule
`default_nettype wire

// ### verilog/ddc_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddc_consts.svh"

module ddc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ddc_pkg::ddc_pins_type raw,
  output wire ddc_pkg::ddc_pins_type synced
);

  localparam int N = $bits(ddc_pkg::ddc_pins_type);
  localparam logic [N-1:0] IDLE_VAL = `DDC_PIN_IDLE;

  logic [N-1:0] raw_vec;
  logic [N-1:0] meta_reg;
  logic [N-1:0] hold_reg;

  assign raw_vec = raw;
  assign synced = hold_reg;

  // ************************************************************
  // Two-stage synchronisers, chip select resting high
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // Only the second stage is visible outside
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_reg[g] <= IDLE_VAL[g];
          hold_reg[g] <= IDLE_VAL[g];
        end else begin
          meta_reg[g] <= raw_vec[g];
          hold_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
